// [common/fsr_pkg.sv]
// Purpose: constants and carrier types for the flash status/config register bank
// Assumes: one 10 MHz clock, synchronous active-high reset
// Notes:   command codes and bit positions of the three status bytes live here
// What this block does
// - erase suspend flag, read-only, status two bit 7
// - complement protect at status two bit 6
// - three OTP security locks, status two bits 5..3
// - program suspend flag, read-only, status two bit 2
// - quad enable bit 1 disables protect/pause pins
// - status protect high at status two bit 0
// - pin function select: pause or clear, quad off
// - drive strength field bits 6..5, used on reads
// - high frequency select bit 4, defaults to one
// - status three bits 3,1 reserved, don't care
// - protect scheme select bit 2 picks protection method
// - dummy cycle select bit 0 of status three
// - busy set during program, erase, stored (non-volatile) status write
// - busy clears when operation finishes
// - write enable command sets write enable latch
// - latch cleared by disable, program, erase, status write
// - block protect bits 4..2 written by status write
// - block protect defaults to zero, nothing protected
// - top/bottom select bit 5, top when zero
// - top/bottom changes only when write permitted
// - volatile copies load from stored; 50h targets volatile
// - protect 00 latch,01 pin,10 power,11 permanent
// - dummy cycles 4/8 dual, 6/10 quad
package fsr_pkg;

  // command codes
  localparam logic [7:0] CMD_WRITE_ENABLE   = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE  = 8'h04;
  localparam logic [7:0] CMD_VOLATILE_WREN  = 8'h50;
  localparam logic [7:0] CMD_WRITE_STATUS1  = 8'h01;
  localparam logic [7:0] CMD_WRITE_STATUS2  = 8'h31;
  localparam logic [7:0] CMD_WRITE_STATUS3  = 8'h11;
  localparam logic [7:0] CMD_READ_STATUS1   = 8'h05;
  localparam logic [7:0] CMD_READ_STATUS2   = 8'h35;
  localparam logic [7:0] CMD_READ_STATUS3   = 8'h15;
  localparam logic [7:0] CMD_PAGE_PROGRAM   = 8'h02;
  localparam logic [7:0] CMD_SECTOR_ERASE   = 8'h20;
  localparam logic [7:0] CMD_BLOCK_ERASE32  = 8'h52;
  localparam logic [7:0] CMD_BLOCK_ERASE64  = 8'hD8;
  localparam logic [7:0] CMD_CHIP_ERASE     = 8'hC7;
  localparam logic [7:0] CMD_SOFT_RESET     = 8'h99;

  // status byte one fields
  localparam int S1_BUSY   = 0;
  localparam int S1_WLATCH = 1;
  localparam int S1_BP_LO  = 2;
  localparam int S1_BP_HI  = 4;
  localparam int S1_TOPBOT = 5;
  localparam int S1_SMALL  = 6;
  localparam int S1_SPLO   = 7;
  // status byte two fields
  localparam int S2_SPHI   = 0;
  localparam int S2_QUAD   = 1;
  localparam int S2_PSUS   = 2;
  localparam int S2_LB_LO  = 3;
  localparam int S2_LB_HI  = 5;
  localparam int S2_COMPL  = 6;
  localparam int S2_ESUS   = 7;
  // status byte three fields
  localparam int S3_DUMMY  = 0;
  localparam int S3_RSV1   = 1;
  localparam int S3_SCHEME = 2;
  localparam int S3_RSV3   = 3;
  localparam int S3_HFREQ  = 4;
  localparam int S3_DRV_LO = 5;
  localparam int S3_DRV_HI = 6;
  localparam int S3_PFS    = 7;

  // writable masks: status bits that a status write may touch
  localparam logic [7:0] S1_WMASK = 8'hFC;
  localparam logic [7:0] S2_WMASK = 8'h7B;
  localparam logic [7:0] S2_VMASK = 8'h43;   // no volatile lock bits
  localparam logic [7:0] S3_WMASK = 8'hF5;   // reserved 3 and 1 dropped

  // reset values of stored configuration
  localparam logic [7:0] S1_RESET = 8'h00;
  localparam logic [7:0] S2_RESET = 8'h00;
  localparam logic [7:0] S3_RESET = 8'h10;

  // dummy cycle counts
  localparam logic [3:0] DUMMY_DUAL_LO = 4'h4;
  localparam logic [3:0] DUMMY_DUAL_HI = 4'h8;
  localparam logic [3:0] DUMMY_QUAD_LO = 4'h6;
  localparam logic [3:0] DUMMY_QUAD_HI = 4'hA;

  // status protect modes
  localparam logic [1:0] SP_SOFTWARE = 2'b00;
  localparam logic [1:0] SP_HARDWARE = 2'b01;
  localparam logic [1:0] SP_POWER    = 2'b10;
  localparam logic [1:0] SP_OTP      = 2'b11;

  // command strobe from the serial front end
  typedef struct packed {
    logic       valid;   // one-cycle strobe
    logic [7:0] opcode;  // command code
    logic [7:0] data;    // data byte for status writes
  } fsr_cmd_t;

  // decoded configuration handed to the rest of the device
  typedef struct packed {
    logic [2:0] block_protect;
    logic       top_bottom_select;
    logic       small_unit_select;
    logic       complement_protect;
    logic       protect_scheme_select;
    logic [1:0] drive_strength;
    logic       high_freq_select;
    logic       quad_enable;
    logic       pause_pin_en;
    logic       clear_pin_en;
    logic       write_protect_pin_en;
    logic [2:0] security_lock;
    logic [3:0] dual_dummy;
    logic [3:0] quad_dummy;
  } fsr_cfg_t;

endpackage : fsr_pkg

// [src/fsr_bank.sv]
// Purpose: status and configuration register bank of a serial flash
// Assumes: command strobes are already decoded on i_clock by the serial front end
// Notes:   the stored (non-volatile) image is held in flops; a write of it
//          takes NV_WRITE_CYCLES cycles to mimic the slow cell write
`timescale 1ns/1ps
module fsr_bank #(
  parameter int NV_WRITE_CYCLES = 16                // stored-image write time in cycles
) (
  input  wire logic             i_clock,            // 10 MHz system clock
  input  wire logic             i_sys_rst,          // synchronous reset, active high
  input  wire fsr_pkg::fsr_cmd_t i_cmd,             // command strobe
  input  wire logic             i_write_protect_n,  // write protect pin, active low
  input  wire logic             i_array_busy,       // program/erase engine running
  input  wire logic             i_erase_suspended,  // erase suspend state from engine
  input  wire logic             i_program_suspended,// program suspend state from engine
  output logic                  o_cmd_accept,       // command taken (not refused)
  output logic [7:0]            o_read_data,        // status byte for read commands
  output logic                  o_read_valid,       // read data strobe
  output logic                  o_busy,             // busy status
  output logic                  o_write_enable_latch,// latch state
  output fsr_pkg::fsr_cfg_t     o_cfg               // live configuration
);

  // synchronised protect pin
  logic wp_meta;        // first stage, read only by second stage
  logic wp_sync;        // usable level
  // stored and live copies
  logic [7:0] nv_one, nv_two, nv_three;   // stored image
  logic [7:0] vol_one, vol_two, vol_three;// live image controlling behaviour
  logic       write_enable_latch;
  logic       volatile_armed;             // 50h seen, next status write is volatile
  logic       power_lock;                 // protect 10 latched lock
  logic       status_busy;                // stored-image write in progress
  logic [$clog2(NV_WRITE_CYCLES+1)-1:0] nv_count;
  logic       erase_susp, prog_susp;      // suspend flags
  // decode
  logic       busy_now;
  logic       is_status_write;
  logic       is_array_op;
  logic       is_read;
  logic       accept;
  logic       write_permit;
  logic [1:0] protect_mode;
  logic [7:0] wr_mask;
  logic [7:0] next_stat;

  // two-flop synchroniser for the protect pin
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      wp_meta <= 1'b1;
      wp_sync <= 1'b1;
    end else begin
      wp_meta <= i_write_protect_n;
      wp_sync <= wp_meta;
    end
  end

  // busy covers array operations and stored-image writes
  assign busy_now = status_busy | i_array_busy;

  // command classification
  assign is_status_write = (i_cmd.opcode == fsr_pkg::CMD_WRITE_STATUS1) |
                           (i_cmd.opcode == fsr_pkg::CMD_WRITE_STATUS2) |
                           (i_cmd.opcode == fsr_pkg::CMD_WRITE_STATUS3);
  assign is_array_op = (i_cmd.opcode == fsr_pkg::CMD_PAGE_PROGRAM) |
                       (i_cmd.opcode == fsr_pkg::CMD_SECTOR_ERASE) |
                       (i_cmd.opcode == fsr_pkg::CMD_BLOCK_ERASE32) |
                       (i_cmd.opcode == fsr_pkg::CMD_BLOCK_ERASE64) |
                       (i_cmd.opcode == fsr_pkg::CMD_CHIP_ERASE);
  assign is_read = (i_cmd.opcode == fsr_pkg::CMD_READ_STATUS1) |
                   (i_cmd.opcode == fsr_pkg::CMD_READ_STATUS2) |
                   (i_cmd.opcode == fsr_pkg::CMD_READ_STATUS3);

  // while busy only status reads get through
  assign accept = i_cmd.valid & (~busy_now | is_read);

  // protection mode from the live protect bits
  assign protect_mode = {vol_two[fsr_pkg::S2_SPHI], vol_one[fsr_pkg::S1_SPLO]};

  // write permission: latch or volatile arm, then the protect mode
  always_comb begin
    write_permit = write_enable_latch | volatile_armed;
    case (protect_mode)
      fsr_pkg::SP_SOFTWARE: write_permit = write_permit;
      fsr_pkg::SP_HARDWARE: write_permit = write_permit & (wp_sync | vol_two[fsr_pkg::S2_QUAD]);
      fsr_pkg::SP_POWER:    write_permit = write_permit & ~power_lock;
      fsr_pkg::SP_OTP:      write_permit = 1'b0;
      default:              write_permit = 1'b0;
    endcase
  end

  // write mask per target byte; volatile writes never touch lock bits
  always_comb begin
    case (i_cmd.opcode)
      fsr_pkg::CMD_WRITE_STATUS1: wr_mask = fsr_pkg::S1_WMASK;
      fsr_pkg::CMD_WRITE_STATUS2: wr_mask = volatile_armed ? fsr_pkg::S2_VMASK
                                                           : fsr_pkg::S2_WMASK;
      fsr_pkg::CMD_WRITE_STATUS3: wr_mask = fsr_pkg::S3_WMASK;
      default:                    wr_mask = 8'h00;
    endcase
  end

  // masked merge helper for one status byte
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] din,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (din & mask);
  endfunction : merge

  // status write of the second byte: lock bits are one-way
  always_comb begin
    next_stat = merge(nv_two, i_cmd.data, wr_mask);
    next_stat[fsr_pkg::S2_LB_HI:fsr_pkg::S2_LB_LO] =
      nv_two[fsr_pkg::S2_LB_HI:fsr_pkg::S2_LB_LO] |
      (i_cmd.data[fsr_pkg::S2_LB_HI:fsr_pkg::S2_LB_LO] &
       wr_mask[fsr_pkg::S2_LB_HI:fsr_pkg::S2_LB_LO]);
  end

  // stored image: updated only by permitted non-volatile status writes
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      nv_one   <= fsr_pkg::S1_RESET;
      nv_two   <= fsr_pkg::S2_RESET;
      nv_three <= fsr_pkg::S3_RESET;
    end else if (accept & is_status_write & write_permit & ~volatile_armed) begin
      case (i_cmd.opcode)
        fsr_pkg::CMD_WRITE_STATUS1: nv_one   <= merge(nv_one, i_cmd.data, wr_mask);
        fsr_pkg::CMD_WRITE_STATUS2: nv_two   <= next_stat;
        fsr_pkg::CMD_WRITE_STATUS3: nv_three <= merge(nv_three, i_cmd.data, wr_mask);
        default:                    nv_one   <= nv_one;
      endcase
    end
  end

  // live image: reloaded from the stored one on soft reset, written directly by volatile writes
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      vol_one   <= fsr_pkg::S1_RESET;
      vol_two   <= fsr_pkg::S2_RESET;
      vol_three <= fsr_pkg::S3_RESET;
    end else if (accept & (i_cmd.opcode == fsr_pkg::CMD_SOFT_RESET)) begin
      vol_one   <= nv_one;
      vol_two   <= nv_two;
      vol_three <= nv_three;
    end else if (accept & is_status_write & write_permit) begin
      // both kinds of write take effect on the live copy at once
      case (i_cmd.opcode)
        fsr_pkg::CMD_WRITE_STATUS1: vol_one   <= merge(vol_one, i_cmd.data, wr_mask);
        fsr_pkg::CMD_WRITE_STATUS2: vol_two   <= volatile_armed ? merge(vol_two, i_cmd.data, wr_mask)
                                                                : next_stat;
        fsr_pkg::CMD_WRITE_STATUS3: vol_three <= merge(vol_three, i_cmd.data, wr_mask);
        default:                    vol_one   <= vol_one;
      endcase
    end
  end

  // power-supply lock: once protect mode 10 is live, writes stay locked until reset
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      power_lock <= 1'b0;
    end else if (accept & (i_cmd.opcode == fsr_pkg::CMD_SOFT_RESET)) begin
      power_lock <= 1'b0;
    end else if (protect_mode == fsr_pkg::SP_POWER) begin
      power_lock <= 1'b1;
    end
  end

  // write enable latch and volatile arm
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      write_enable_latch <= 1'b0;
      volatile_armed     <= 1'b0;
    end else if (accept) begin
      if (i_cmd.opcode == fsr_pkg::CMD_WRITE_ENABLE) begin
        write_enable_latch <= 1'b1;
        volatile_armed     <= 1'b0;
      end else if (i_cmd.opcode == fsr_pkg::CMD_VOLATILE_WREN) begin
        volatile_armed     <= 1'b1;
      end else if ((i_cmd.opcode == fsr_pkg::CMD_WRITE_DISABLE) | is_array_op | is_status_write |
                   (i_cmd.opcode == fsr_pkg::CMD_SOFT_RESET)) begin
        write_enable_latch <= 1'b0;
        volatile_armed     <= 1'b0;
      end
    end
  end

  // stored-image write timer keeps busy high for a fixed time
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      status_busy <= 1'b0;
      nv_count    <= '0;
    end else if (accept & is_status_write & write_permit & ~volatile_armed) begin
      status_busy <= 1'b1;
      nv_count    <= ($clog2(NV_WRITE_CYCLES+1))'(NV_WRITE_CYCLES - 1);
    end else if (status_busy) begin
      if (nv_count == '0) begin
        status_busy <= 1'b0;
      end else begin
        nv_count <= nv_count - 1'b1;
      end
    end
  end

  // suspend flags follow the array engine; cleared by reset
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      erase_susp <= 1'b0;
      prog_susp  <= 1'b0;
    end else begin
      erase_susp <= i_erase_suspended;
      prog_susp  <= i_program_suspended;
    end
  end

  // status reads assemble volatile flags around the live image
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_read_data  <= 8'h00;
      o_read_valid <= 1'b0;
    end else begin
      o_read_valid <= accept & is_read;
      case (i_cmd.opcode)
        fsr_pkg::CMD_READ_STATUS1:
          o_read_data <= {vol_one[7:2], write_enable_latch, busy_now};
        fsr_pkg::CMD_READ_STATUS2:
          o_read_data <= {erase_susp, vol_two[6:3], prog_susp, vol_two[1:0]};
        fsr_pkg::CMD_READ_STATUS3:
          o_read_data <= vol_three & fsr_pkg::S3_WMASK;
        default:
          o_read_data <= o_read_data;
      endcase
    end
  end

  // registered outputs and decoded configuration
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_cmd_accept         <= 1'b0;
      o_busy               <= 1'b0;
      o_write_enable_latch <= 1'b0;
      o_cfg                <= '0;
    end else begin
      o_cmd_accept         <= accept;
      o_busy               <= busy_now;
      o_write_enable_latch <= write_enable_latch;
      o_cfg.block_protect         <= vol_one[fsr_pkg::S1_BP_HI:fsr_pkg::S1_BP_LO];
      o_cfg.top_bottom_select     <= vol_one[fsr_pkg::S1_TOPBOT];
      o_cfg.small_unit_select     <= vol_one[fsr_pkg::S1_SMALL];
      o_cfg.complement_protect    <= vol_two[fsr_pkg::S2_COMPL];
      o_cfg.security_lock         <= vol_two[fsr_pkg::S2_LB_HI:fsr_pkg::S2_LB_LO];
      o_cfg.quad_enable           <= vol_two[fsr_pkg::S2_QUAD];
      o_cfg.write_protect_pin_en  <= ~vol_two[fsr_pkg::S2_QUAD];
      o_cfg.pause_pin_en          <= ~vol_two[fsr_pkg::S2_QUAD] & ~vol_three[fsr_pkg::S3_PFS];
      o_cfg.clear_pin_en          <= ~vol_two[fsr_pkg::S2_QUAD] & vol_three[fsr_pkg::S3_PFS];
      o_cfg.drive_strength        <= vol_three[fsr_pkg::S3_DRV_HI:fsr_pkg::S3_DRV_LO];
      o_cfg.high_freq_select      <= vol_three[fsr_pkg::S3_HFREQ];
      o_cfg.protect_scheme_select <= vol_three[fsr_pkg::S3_SCHEME];
      o_cfg.dual_dummy <= vol_three[fsr_pkg::S3_DUMMY] ? fsr_pkg::DUMMY_DUAL_HI : fsr_pkg::DUMMY_DUAL_LO;
      o_cfg.quad_dummy <= vol_three[fsr_pkg::S3_DUMMY] ? fsr_pkg::DUMMY_QUAD_HI : fsr_pkg::DUMMY_QUAD_LO;
    end
  end

endmodule : fsr_bank

// [test/fsr_bank_monitor.sv]
// Purpose: port-level checks on the status register bank
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound into every bank instance; sees ports only
`timescale 1ns/1ps
module fsr_bank_monitor #(
  parameter int NV_WRITE_CYCLES = 16                 // stored-image write time, from the bank
) (
  input wire logic              i_clock,
  input wire logic              i_sys_rst,
  input wire fsr_pkg::fsr_cmd_t i_cmd,
  input wire logic              i_write_protect_n,
  input wire logic              i_array_busy,
  input wire logic              i_erase_suspended,
  input wire logic              i_program_suspended,
  input wire logic              o_cmd_accept,
  input wire logic [7:0]        o_read_data,
  input wire logic              o_read_valid,
  input wire logic              o_busy,
  input wire logic              o_write_enable_latch,
  input wire fsr_pkg::fsr_cfg_t o_cfg
);
  localparam int BUSY_MAX = NV_WRITE_CYCLES + 2;     // two spare for the registered flag
  logic is_rd;                                       // status reads pass even while busy
  logic is_clr;                                      // opcodes that drop the latch
  logic live;                                        // cfg settles one edge after reset
  assign is_rd  = i_cmd.opcode inside {8'h05, 8'h35, 8'h15};
  assign is_clr = i_cmd.opcode inside {8'h04, 8'h01, 8'h31, 8'h11, 8'h02, 8'h20, 8'h52, 8'hD8, 8'hC7};
  // first edge after release still shows the reset outputs, so cfg checks wait one edge
  always_ff @(posedge i_clock) begin
    live <= !i_sys_rst;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  sequence s_rd_taken;
    i_cmd.valid && is_rd;
  endsequence
  sequence s_wren_taken;
    i_cmd.valid && i_cmd.opcode == 8'h06 ##1 o_cmd_accept;
  endsequence
  property p_read_pair;  s_rd_taken |=> o_cmd_accept && o_read_valid; endproperty
  property p_rv_acc;     o_read_valid |-> o_cmd_accept; endproperty
  property p_refuse;     i_cmd.valid && !is_rd && i_array_busy |=> !o_cmd_accept; endproperty
  property p_array_busy; i_array_busy |=> o_busy; endproperty
  property p_busy_end;   $rose(o_busy) && !i_array_busy |-> ##[1:BUSY_MAX] !o_busy; endproperty
  property p_wren;       s_wren_taken |=> o_write_enable_latch; endproperty
  property p_wel_clr;    o_cmd_accept && $past(is_clr) |=> !o_write_enable_latch; endproperty
  property p_dummy;
    live |-> (o_cfg.dual_dummy == 4'h4 && o_cfg.quad_dummy == 4'h6) ||
             (o_cfg.dual_dummy == 4'h8 && o_cfg.quad_dummy == 4'hA);
  endproperty
  property p_quad_pins;
    live && o_cfg.quad_enable |-> !(o_cfg.pause_pin_en || o_cfg.clear_pin_en || o_cfg.write_protect_pin_en);
  endproperty
  property p_pin_sel;
    live && !o_cfg.quad_enable |-> o_cfg.write_protect_pin_en && (o_cfg.pause_pin_en != o_cfg.clear_pin_en);
  endproperty
  a_read_pair:  assert property (p_read_pair) else $error("status read not answered next cycle");
  a_rv_acc:     assert property (p_rv_acc) else $error("read data without accept");
  a_refuse:     assert property (p_refuse) else $error("command taken while array busy");
  a_array_busy: assert property (p_array_busy) else $error("busy not shown for array engine");
  a_busy_end:   assert property (p_busy_end) else $error("status write busy did not end");
  a_wren:       assert property (p_wren) else $error("write enable did not set latch");
  a_wel_clr:    assert property (p_wel_clr) else $error("latch kept after clearing command");
  a_dummy:      assert property (p_dummy) else $error("dummy counts out of pair");
  a_quad_pins:  assert property (p_quad_pins) else $error("pin function left on in quad mode");
  a_pin_sel:    assert property (p_pin_sel) else $error("shared pin function not exclusive");
endmodule : fsr_bank_monitor

bind fsr_bank fsr_bank_monitor #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) fsr_bank_monitor_i (
  .i_clock, .i_sys_rst, .i_cmd, .i_write_protect_n, .i_array_busy, .i_erase_suspended,
  .i_program_suspended, .o_cmd_accept, .o_read_data, .o_read_valid, .o_busy, .o_write_enable_latch, .o_cfg);

// [test/fsr_host.sv]
// Purpose: host controller model issuing status register commands
// Assumes: one-cycle command strobe, answer registered on the taking edge
// Notes:   released fields show the inverse so stale values never match
`timescale 1ns/1ps
module fsr_host (
  input  wire logic         i_clock,
  input  wire logic         i_cmd_accept,
  input  wire logic         i_read_valid,
  input  wire logic [7:0]   i_read_data,
  output fsr_pkg::fsr_cmd_t o_cmd
);
  initial o_cmd = '0;                                // idle strobe from time zero
  // strobe one command; the answer stands only from the taking edge to the next, so sample it there
  task automatic send(input logic [7:0] op, input logic [7:0] d, output logic acc, output logic rv,
                      output logic [7:0] rdata, output logic [7:0] care);
    @(posedge i_clock);
    #1;
    o_cmd = {1'b1, op, d};
    @(posedge i_clock);
    #1;
    o_cmd = {1'b0, ~op, ~d};                         // released: no longer the last value
    acc   = i_cmd_accept;
    rv    = i_read_valid;
    rdata = i_read_data;
    care  = (op == 8'h15) ? 8'hF5 : 8'hFF;
  endtask : send
endmodule : fsr_host

// [test/fsr_bank_test.sv]
// Purpose: self-checking bench for the status register bank
// Assumes: 10 MHz clock, host model drives the command strobe
// Notes:   short stored-write time; random configuration with fixed seed
`timescale 1ns/1ps
module fsr_bank_test;
  localparam int NV = 16;                            // short stored-write time keeps the run brief
  logic              i_clock = 1'b0;
  logic              i_sys_rst = 1'b1;
  fsr_pkg::fsr_cmd_t i_cmd;
  logic              i_write_protect_n = 1'b1;
  logic              i_array_busy = 1'b0;
  logic              i_erase_suspended = 1'b0;
  logic              i_program_suspended = 1'b0;
  logic              o_cmd_accept, o_read_valid, o_busy, o_write_enable_latch;
  logic [7:0]        o_read_data;
  fsr_pkg::fsr_cfg_t o_cfg;
  int                err_count = 0;
  int                checked = 0;
  integer            seed = 32'h771a;
  logic              acc, rv;                        // last answer seen by the host
  logic [7:0]        rd, care, r, en;
  logic [7:0]        e1, e2, e3, n1, n2, n3, lock;   // live and stored expectations
  logic [7:0]        clr [6] = '{8'h04, 8'h02, 8'h20, 8'h52, 8'hD8, 8'hC7};
  always #50 i_clock = ~i_clock;
  fsr_bank #(.NV_WRITE_CYCLES(NV)) fsr_bank_i (.i_clock, .i_sys_rst, .i_cmd, .i_write_protect_n,
    .i_array_busy, .i_erase_suspended, .i_program_suspended, .o_cmd_accept, .o_read_data,
    .o_read_valid, .o_busy, .o_write_enable_latch, .o_cfg);
  fsr_host fsr_host_i (.i_clock, .i_cmd_accept(o_cmd_accept), .i_read_valid(o_read_valid),
    .i_read_data(o_read_data), .o_cmd(i_cmd));
  // byte two as read: written bits, sticky locks, suspend inputs
  function automatic logic [7:0] exp2(input logic [7:0] v);
    return v | lock | {i_erase_suspended, 4'h0, i_program_suspended, 2'b00};
  endfunction : exp2
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] op, input logic [7:0] d, input logic ea);
    fsr_host_i.send(op, d, acc, rv, rd, care);
    chk("accept", {7'h00, ea}, {7'h00, acc});
  endtask : cmd
  task automatic rchk(input logic [7:0] op, input logic [7:0] e);
    cmd(op, 8'h00, 1'b1);
    chk("read_valid", 8'h01, {7'h00, rv});
    chk("status", e & care, rd & care);
  endtask : rchk
  // busy shows one edge after accept, so look one edge on before waiting
  task automatic idle();
    int n = 0;
    @(posedge i_clock);
    #1;
    while (o_busy !== 1'b0 && n < 100) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    chk("busy_end", 8'h00, {7'h00, o_busy});
  endtask : idle
  task automatic wr(input logic [7:0] e, input logic [7:0] op, input logic [7:0] d);
    cmd(e, 8'h00, 1'b1);
    if (e == 8'h06) rchk(8'h05, e1 | 8'h02);
    cmd(op, d, 1'b1);
    idle();
  endtask : wr
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // watchdog: the full sequence needs well under 2000 cycles
  initial begin
    #1_000_000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    {e1, e2, e3, n1, n2, n3, lock} = {8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h10, 8'h00};
    repeat (3) @(posedge i_clock);
    #1;
    i_sys_rst = 1'b0;
    rchk(8'h05, 8'h00);
    rchk(8'h35, 8'h00);
    rchk(8'h15, 8'h10);
    chk("dual_dummy", 8'h04, {4'h0, o_cfg.dual_dummy});
    cmd(8'h01, 8'h20, 1'b1);
    idle();
    rchk(8'h05, 8'h00);
    wr(8'h06, 8'h31, 8'h08);
    lock = 8'h08;
    wr(8'h06, 8'h31, 8'h00);
    rchk(8'h35, exp2(8'h00));
    foreach (clr[i]) begin
      cmd(8'h06, 8'h00, 1'b1);
      cmd(clr[i], 8'h00, 1'b1);
      rchk(8'h05, e1);
    end
    // reads pass and other commands are refused during a stored write
    cmd(8'h06, 8'h00, 1'b1);
    cmd(8'h01, e1, 1'b1);
    @(posedge i_clock);
    #1;
    chk("busy", 8'h01, {7'h00, o_busy});
    cmd(8'h06, 8'h00, 1'b0);
    rchk(8'h05, e1 | 8'h01);
    idle();
    rchk(8'h05, e1);
    i_array_busy = 1'b1;
    cmd(8'h06, 8'h00, 1'b0);
    i_array_busy = 1'b0;
    idle();
    // random configuration, alternating stored and volatile writes
    for (int k = 0; k < 8; k++) begin
      r = $random(seed);
      {i_erase_suspended, i_program_suspended} = {r[3], r[1]};
      en = k[0] ? 8'h50 : 8'h06;
      wr(en, 8'h11, r);
      e3 = r & 8'hF5;
      rchk(8'h15, e3);
      chk("reserved", 8'h00, rd & 8'h0A);
      chk("drive", {6'h00, r[6:5]}, {6'h00, o_cfg.drive_strength});
      chk("dual_dummy", r[0] ? 8'h08 : 8'h04, {4'h0, o_cfg.dual_dummy});
      chk("quad_dummy", r[0] ? 8'h0A : 8'h06, {4'h0, o_cfg.quad_dummy});
      wr(en, 8'h01, r & 8'h7C);
      e1 = r & 8'h7C;
      rchk(8'h05, e1);
      chk("protect", {5'h00, r[4:2]}, {5'h00, o_cfg.block_protect});
      wr(en, 8'h31, r & 8'h42);
      e2 = r & 8'h42;
      rchk(8'h35, exp2(e2));
      chk("clear_pin", {7'h00, e3[7] & ~e2[1]}, {7'h00, o_cfg.clear_pin_en});
      if (en == 8'h06) {n1, n2, n3} = {e1, e2, e3};
    end
    // pin-controlled protection
    wr(8'h50, 8'h31, 8'h00);
    wr(8'h50, 8'h01, e1 | 8'h80);
    e1 = e1 | 8'h80;
    i_write_protect_n = 1'b0;
    repeat (3) @(posedge i_clock);
    wr(8'h06, 8'h01, 8'h1C);
    rchk(8'h05, e1);
    i_write_protect_n = 1'b1;
    repeat (3) @(posedge i_clock);
    wr(8'h50, 8'h01, 8'h00);
    e1 = 8'h00;
    rchk(8'h05, e1);
    // power lock, then soft reset reloads the stored image
    wr(8'h50, 8'h31, 8'h01);
    rchk(8'h35, exp2(8'h01));
    wr(8'h50, 8'h01, 8'h1C);
    rchk(8'h05, 8'h00);
    cmd(8'h99, 8'h00, 1'b1);
    repeat (4) @(posedge i_clock);
    rchk(8'h05, n1);
    rchk(8'h35, exp2(n2));
    rchk(8'h15, n3);
    tally_and_finish();
  end
endmodule : fsr_bank_test
